// *** jtag_flash_programming_port.sv ***
// JTAG flash programming port: TAP, programming registers, flash array
// Behaviour
// R1 - Instruction 0x5 puts the 15-bit command register between TDI and TDO.
// R2 - Capture-DR under command entry loads the previous command's result.
// R3 - Each TCK in Shift-DR shifts the command register once.
// R4 - Update-DR under command entry applies the shifted command word.
// R5 - One execution clock is made in Run-Test/Idle after an applied command.
// R6 - Instruction 0x6 shifts the low eight command bits as data byte.
// R7 - Page-load update copies byte to holding register and writes page buffer.
// R8 - Page-load updates alternate low and high byte, low first.
// R9 - Counter pre-increments before each low byte except the first.
// R10 - Instruction 0x7 captures the addressed flash byte at Capture-DR.
// R11 - Page-read captures alternate low and high byte, low first.
// R12 - Counter post-increments after every high byte capture.
// R13 - A one in the reset register holds the target in reset, unlatched.
// R14 - After release, reset stays for the selected time-out.
// R15 - Programmer resets the target before entering programming mode.
// R16 - Programming enabled only when the 16-bit register equals the signature.
// R17 - Enable register clears on power-on reset; programmer clears it on exit.
// R18 - Chip erase by command words, then polling a completion status bit.
// R19 - Flash write begins with enter command, then address high and low bytes.
// R20 - Data low and high prefixes; latch pulses bit 14 into the page buffer.
// R21 - Page write of three words, then polling until finished.
// R22 - Flash read begins with enter command, same address prefixes.
// R23 - All scan registers shift least significant bit first.
// R24 - Instruction register is four bits wide.
// R25 - Instruction 0xC selects the reset register, TAP itself not reset.
// R26 - Instruction 0x4 selects enable register, compared at Update-DR.
// R27 - Polled status bit reads one when erase or write has completed.
// R28 - Without a matching signature, command, load and read are ignored.
`timescale 1ns/1ps
module jtag_flash_programming_port #(
	parameter logic [17:0] TIMEOUT_SLOW_CYCLES = 18'h3_2000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_en,
	output logic target_reset_n,
	output logic prog_enabled
);
	jp_pkg::pins_t pin_meta, pin_sync, pin_prev;
	jp_pkg::tap_state_t tap_state, next_tap;
	jp_pkg::op_state_t op_state, next_op;
	logic tck_rise, tck_fall, busy, in_dr_tdo;
	logic [3:0] ir_sr, next_ir_sr, ir, next_ir;
	logic [14:0] cmd_sr, next_cmd_sr, applied, next_applied, result_word;
	logic [15:0] en_sr, next_en_sr, pc, next_pc, rd_word, next_rd_word, flash_word, fl_wdata;
	logic rst_sr, next_rst_sr, bypass, next_bypass, next_prog_en;
	logic [7:0] data_lo, next_data_lo, data_hi, next_data_hi, mode, next_mode;
	logic [7:0] hold, next_hold, pb_wlo, pb_whi;
	logic load_hi, next_load_hi, load_first, next_load_first, read_hi, next_read_hi;
	logic exec_pend, next_exec_pend, rd_sel_hi, next_rd_sel_hi;
	logic pl_go, next_pl_go, pl_hi, next_pl_hi, next_tdo, next_tdo_en;
	logic start_erase, start_write, latch_go;
	logic [12:0] op_cnt, next_op_cnt, fl_addr;
	logic fl_we, pb_we_lo, pb_we_hi;
	logic [5:0] pb_addr;
	logic [15:0] flash_mem [jp_pkg::FLASH_WORDS];
	logic [7:0] page_lo [jp_pkg::PAGE_WORDS];
	logic [7:0] page_hi [jp_pkg::PAGE_WORDS];
	logic rst_prev, next_rst_prev, next_target_reset_n;
	logic [17:0] tmo_cnt, next_tmo_cnt;
	logic [1:0] ctrl, next_ctrl;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	// Pin synchroniser; logic reads pin_sync and pin_prev, never pin_meta
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end else begin
			pin_meta <= '{tck: tck, tms: tms, tdi: tdi};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	assign tck_rise = pin_sync.tck & ~pin_prev.tck;
	assign tck_fall = ~pin_sync.tck & pin_prev.tck;
	assign busy = (op_state != jp_pkg::OP_IDLE);
	assign flash_word = flash_mem[pc[12:0]];
	// Status bit 9 is one once erase or page write has finished
	assign result_word = {5'h00, ~busy, 1'b0, rd_sel_hi ? rd_word[15:8] : rd_word[7:0]}; // [R27]
	// TAP state walk, held in reset while software disables the port
	always_comb begin
		next_tap = tap_state;
		if (tck_rise) begin
			case (tap_state)
				jp_pkg::TLR: next_tap = pin_sync.tms ? jp_pkg::TLR : jp_pkg::RTI;
				jp_pkg::RTI: next_tap = pin_sync.tms ? jp_pkg::SEL_DR : jp_pkg::RTI;
				jp_pkg::SEL_DR: next_tap = pin_sync.tms ? jp_pkg::SEL_IR : jp_pkg::CAP_DR;
				jp_pkg::CAP_DR: next_tap = pin_sync.tms ? jp_pkg::EX1_DR : jp_pkg::SH_DR;
				jp_pkg::SH_DR: next_tap = pin_sync.tms ? jp_pkg::EX1_DR : jp_pkg::SH_DR;
				jp_pkg::EX1_DR: next_tap = pin_sync.tms ? jp_pkg::UPD_DR : jp_pkg::PA_DR;
				jp_pkg::PA_DR: next_tap = pin_sync.tms ? jp_pkg::EX2_DR : jp_pkg::PA_DR;
				jp_pkg::EX2_DR: next_tap = pin_sync.tms ? jp_pkg::UPD_DR : jp_pkg::SH_DR;
				jp_pkg::UPD_DR: next_tap = pin_sync.tms ? jp_pkg::SEL_DR : jp_pkg::RTI;
				jp_pkg::SEL_IR: next_tap = pin_sync.tms ? jp_pkg::TLR : jp_pkg::CAP_IR;
				jp_pkg::CAP_IR: next_tap = pin_sync.tms ? jp_pkg::EX1_IR : jp_pkg::SH_IR;
				jp_pkg::SH_IR: next_tap = pin_sync.tms ? jp_pkg::EX1_IR : jp_pkg::SH_IR;
				jp_pkg::EX1_IR: next_tap = pin_sync.tms ? jp_pkg::UPD_IR : jp_pkg::PA_IR;
				jp_pkg::PA_IR: next_tap = pin_sync.tms ? jp_pkg::EX2_IR : jp_pkg::PA_IR;
				jp_pkg::EX2_IR: next_tap = pin_sync.tms ? jp_pkg::UPD_IR : jp_pkg::SH_IR;
				jp_pkg::UPD_IR: next_tap = pin_sync.tms ? jp_pkg::SEL_DR : jp_pkg::RTI;
				default: next_tap = jp_pkg::TLR;
			endcase
		end
		if (!ctrl[0]) begin
			next_tap = jp_pkg::TLR;
		end
	end
	// Scan registers and programming command path
	always_comb begin
		next_ir_sr = ir_sr;
		next_ir = ir;
		next_cmd_sr = cmd_sr;
		next_en_sr = en_sr;
		next_rst_sr = rst_sr;
		next_bypass = bypass;
		next_applied = applied;
		next_prog_en = prog_enabled;
		next_pc = pc;
		next_data_lo = data_lo;
		next_data_hi = data_hi;
		next_mode = mode;
		next_load_hi = load_hi;
		next_load_first = load_first;
		next_read_hi = read_hi;
		next_exec_pend = exec_pend;
		next_rd_word = rd_word;
		next_rd_sel_hi = rd_sel_hi;
		next_hold = hold;
		next_pl_go = 1'b0;
		next_pl_hi = pl_hi;
		next_tdo = tdo;
		next_tdo_en = tdo_en;
		start_erase = 1'b0;
		start_write = 1'b0;
		latch_go = 1'b0;
		case (ir)
			jp_pkg::IR_COMMAND, jp_pkg::IR_PAGE_LOAD, jp_pkg::IR_PAGE_READ: in_dr_tdo = cmd_sr[0];
			jp_pkg::IR_PROGRAMMING_ENABLE: in_dr_tdo = en_sr[0];
			jp_pkg::IR_TARGET_RESET: in_dr_tdo = rst_sr;
			default: in_dr_tdo = bypass;
		endcase
		if (tck_rise) begin
			case (tap_state)
				jp_pkg::CAP_IR: next_ir_sr = jp_pkg::IR_CAPTURE;
				jp_pkg::SH_IR: next_ir_sr = {pin_sync.tdi, ir_sr[3:1]}; // [R23] [R24]
				jp_pkg::UPD_IR: begin
					next_ir = ir_sr;
					next_load_hi = 1'b0; // [R8]
					next_load_first = 1'b1;
					next_read_hi = 1'b0; // [R11]
				end
				jp_pkg::CAP_DR: begin
					if (ir == jp_pkg::IR_COMMAND) begin
						next_cmd_sr = result_word; // [R2] [R18] [R21]
					end else if (ir == jp_pkg::IR_PAGE_READ && prog_enabled) begin
						next_cmd_sr[7:0] = read_hi ? flash_word[15:8] : flash_word[7:0]; // [R10]
						next_read_hi = ~read_hi; // [R11]
						next_pc = pc + {15'h0000, read_hi}; // [R12]
					end else begin
						next_bypass = 1'b0;
					end
				end
				jp_pkg::SH_DR: begin
					case (ir)
						jp_pkg::IR_COMMAND: next_cmd_sr = {pin_sync.tdi, cmd_sr[14:1]}; // [R1] [R3] [R23]
						jp_pkg::IR_PAGE_LOAD, jp_pkg::IR_PAGE_READ: begin
							next_cmd_sr[7:0] = {pin_sync.tdi, cmd_sr[7:1]}; // [R6]
						end
						jp_pkg::IR_PROGRAMMING_ENABLE: next_en_sr = {pin_sync.tdi, en_sr[15:1]};
						jp_pkg::IR_TARGET_RESET: next_rst_sr = pin_sync.tdi; // [R25]
						default: next_bypass = pin_sync.tdi;
					endcase
				end
				jp_pkg::UPD_DR: begin
					case (ir)
						jp_pkg::IR_PROGRAMMING_ENABLE: begin
							next_prog_en = (en_sr == jp_pkg::ENABLE_SIGNATURE); // [R16] [R26]
						end
						jp_pkg::IR_COMMAND: begin
							if (prog_enabled) begin // [R28]
								next_applied = cmd_sr; // [R4]
								next_exec_pend = 1'b1;
								case (cmd_sr[14:8])
									jp_pkg::PFX_ENTER: next_mode = cmd_sr[7:0]; // [R19] [R22]
									jp_pkg::PFX_ADDR_HI: next_pc[15:8] = cmd_sr[7:0]; // [R19]
									jp_pkg::PFX_ADDR_LO: next_pc[7:0] = cmd_sr[7:0]; // [R19]
									jp_pkg::PFX_DATA_LO: next_data_lo = cmd_sr[7:0]; // [R20]
									jp_pkg::PFX_DATA_HI: next_data_hi = cmd_sr[7:0]; // [R20]
									default: next_mode = mode;
								endcase
							end
						end
						jp_pkg::IR_PAGE_LOAD: begin
							if (prog_enabled) begin // [R28]
								next_hold = cmd_sr[7:0]; // [R7]
								next_pl_go = 1'b1;
								next_pl_hi = load_hi;
								next_load_hi = ~load_hi; // [R8]
								next_load_first = 1'b0;
								next_pc = pc + {15'h0000, ~load_hi & ~load_first}; // [R9]
							end
						end
						default: next_bypass = bypass;
					endcase
				end
				jp_pkg::RTI: begin
					if (exec_pend) begin
						next_exec_pend = 1'b0; // [R5]
						case (applied[14:8])
							jp_pkg::PFX_ERASE_START: start_erase = applied[jp_pkg::ERASE_BIT] & ~busy; // [R18]
							jp_pkg::PFX_PAGE_WRITE: start_write = mode[jp_pkg::MODE_WRITE_BIT] & ~busy; // [R21]
							jp_pkg::PFX_LATCH: latch_go = 1'b1; // [R20]
							jp_pkg::PFX_READ_FETCH: next_rd_word = flash_word; // [R22]
							jp_pkg::PFX_READ_LOW: next_rd_sel_hi = 1'b0;
							jp_pkg::PFX_READ_HIGH: next_rd_sel_hi = mode[jp_pkg::MODE_READ_BIT];
							default: next_rd_sel_hi = rd_sel_hi;
						endcase
					end
				end
				default: next_bypass = bypass;
			endcase
		end
		// TDO changes on the falling TCK edge, LSB of the chosen path
		if (tck_fall) begin
			next_tdo_en = (tap_state == jp_pkg::SH_DR) || (tap_state == jp_pkg::SH_IR);
			next_tdo = (tap_state == jp_pkg::SH_IR) ? ir_sr[0] : in_dr_tdo; // [R23]
		end
	end
	// Page buffer and flash write ports
	always_comb begin
		pb_addr = pc[5:0];
		pb_we_lo = (pl_go & ~pl_hi) | latch_go; // [R7] [R20]
		pb_we_hi = (pl_go & pl_hi) | latch_go;
		pb_wlo = latch_go ? data_lo : hold;
		pb_whi = latch_go ? data_hi : hold;
		next_op = op_state;
		next_op_cnt = op_cnt;
		fl_we = 1'b0;
		fl_addr = op_cnt;
		fl_wdata = jp_pkg::ERASED_WORD;
		case (op_state)
			jp_pkg::OP_IDLE: begin
				next_op_cnt = '0;
				if (start_erase) begin
					next_op = jp_pkg::OP_ERASE;
				end else if (start_write) begin
					next_op = jp_pkg::OP_WRITE;
				end
			end
			jp_pkg::OP_ERASE: begin
				fl_we = 1'b1; // [R18]
				next_op_cnt = op_cnt + 13'h0001;
				if (op_cnt == jp_pkg::FLASH_LAST) begin
					next_op = jp_pkg::OP_IDLE;
				end
			end
			jp_pkg::OP_WRITE: begin
				fl_we = 1'b1; // [R21]
				fl_addr = {pc[12:6], op_cnt[5:0]};
				fl_wdata = {page_hi[op_cnt[5:0]], page_lo[op_cnt[5:0]]};
				next_op_cnt = op_cnt + 13'h0001;
				if (op_cnt == jp_pkg::PAGE_LAST) begin
					next_op = jp_pkg::OP_IDLE;
				end
			end
			default: next_op = jp_pkg::OP_IDLE;
		endcase
	end
	always_ff @(posedge pclk) begin
		if (pb_we_lo) begin
			page_lo[pb_addr] <= pb_wlo;
		end
		if (pb_we_hi) begin
			page_hi[pb_addr] <= pb_whi;
		end
		if (fl_we) begin
			flash_mem[fl_addr] <= fl_wdata;
		end
	end
	// Target reset with time-out after the reset bit is released
	always_comb begin
		next_rst_prev = rst_sr;
		next_tmo_cnt = tmo_cnt;
		if (rst_prev && !rst_sr) begin
			next_tmo_cnt = ctrl[1] ? TIMEOUT_SLOW_CYCLES : jp_pkg::TIMEOUT_FAST_CYCLES; // [R14]
		end else if (tmo_cnt != '0) begin
			next_tmo_cnt = tmo_cnt - 18'h0_0001;
		end
		next_target_reset_n = ~(rst_sr | rst_prev | (tmo_cnt != '0)); // [R13] [R15]
	end
	// APB slave, zero wait state, one register word each
	always_comb begin
		next_ctrl = ctrl;
		next_pready = psel & ~penable;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				jp_pkg::ADDR_CTRL: next_prdata = {30'h0000_0000, ctrl};
				jp_pkg::ADDR_STATUS: begin
					next_prdata = {24'h00_0000, ir, 1'b0, busy, ~target_reset_n, prog_enabled};
				end
				jp_pkg::ADDR_PC: next_prdata = {16'h0000, pc};
				default: next_pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pready && pwrite && paddr == jp_pkg::ADDR_CTRL) begin
			next_ctrl = pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_state <= jp_pkg::TLR;
			op_state <= jp_pkg::OP_IDLE;
			op_cnt <= '0;
			ir_sr <= '0;
			ir <= jp_pkg::IR_CAPTURE;
			cmd_sr <= '0;
			en_sr <= '0;
			rst_sr <= 1'b0;
			bypass <= 1'b0;
			applied <= '0;
			prog_enabled <= 1'b0; // [R17]
			pc <= '0;
			data_lo <= '0;
			data_hi <= '0;
			mode <= '0;
			load_hi <= 1'b0;
			load_first <= 1'b1;
			read_hi <= 1'b0;
			exec_pend <= 1'b0;
			rd_word <= '0;
			rd_sel_hi <= 1'b0;
			hold <= '0;
			pl_go <= 1'b0;
			pl_hi <= 1'b0;
			tdo <= 1'b0;
			tdo_en <= 1'b0;
			rst_prev <= 1'b0;
			tmo_cnt <= '0;
			target_reset_n <= 1'b0;
			ctrl <= jp_pkg::CTRL_RESET;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			tap_state <= next_tap;
			op_state <= next_op;
			op_cnt <= next_op_cnt;
			ir_sr <= next_ir_sr;
			ir <= next_ir;
			cmd_sr <= next_cmd_sr;
			en_sr <= next_en_sr;
			rst_sr <= next_rst_sr;
			bypass <= next_bypass;
			applied <= next_applied;
			prog_enabled <= next_prog_en;
			pc <= next_pc;
			data_lo <= next_data_lo;
			data_hi <= next_data_hi;
			mode <= next_mode;
			load_hi <= next_load_hi;
			load_first <= next_load_first;
			read_hi <= next_read_hi;
			exec_pend <= next_exec_pend;
			rd_word <= next_rd_word;
			rd_sel_hi <= next_rd_sel_hi;
			hold <= next_hold;
			pl_go <= next_pl_go;
			pl_hi <= next_pl_hi;
			tdo <= next_tdo;
			tdo_en <= next_tdo_en;
			rst_prev <= next_rst_prev;
			tmo_cnt <= next_tmo_cnt;
			target_reset_n <= next_target_reset_n;
			ctrl <= next_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end
endmodule

// *** jp_pkg.sv ***
// Constants, codes and types for the JTAG flash programming port
package jp_pkg;
	localparam logic [3:0] IR_PROGRAMMING_ENABLE = 4'h4;
	localparam logic [3:0] IR_COMMAND = 4'h5;
	localparam logic [3:0] IR_PAGE_LOAD = 4'h6;
	localparam logic [3:0] IR_PAGE_READ = 4'h7;
	localparam logic [3:0] IR_TARGET_RESET = 4'hc;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [15:0] ENABLE_SIGNATURE = 16'ha370;
	localparam logic [6:0] PFX_ENTER = 7'h23;
	localparam logic [6:0] PFX_ADDR_HI = 7'h07;
	localparam logic [6:0] PFX_ADDR_LO = 7'h03;
	localparam logic [6:0] PFX_DATA_LO = 7'h13;
	localparam logic [6:0] PFX_DATA_HI = 7'h17;
	localparam logic [6:0] PFX_ERASE_START = 7'h31;
	localparam logic [6:0] PFX_PAGE_WRITE = 7'h35;
	localparam logic [6:0] PFX_LATCH = 7'h77;
	localparam logic [6:0] PFX_READ_FETCH = 7'h32;
	localparam logic [6:0] PFX_READ_LOW = 7'h36;
	localparam logic [6:0] PFX_READ_HIGH = 7'h37;
	localparam int MODE_WRITE_BIT = 4;
	localparam int MODE_READ_BIT = 1;
	localparam int ERASE_BIT = 7;
	localparam int FLASH_AW = 13;
	localparam int PAGE_AW = 6;
	localparam int FLASH_WORDS = 8192;
	localparam int PAGE_WORDS = 64;
	localparam logic [12:0] FLASH_LAST = 13'h1fff;
	localparam logic [12:0] PAGE_LAST = 13'h003f;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_PC = 12'h008;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int TIMEOUT_W = 18;
	localparam logic [17:0] TIMEOUT_FAST_CYCLES = 18'h0_0040;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} pins_t;

	typedef enum logic [15:0] {
		TLR = 16'h0001,
		RTI = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SH_DR = 16'h0010,
		EX1_DR = 16'h0020,
		PA_DR = 16'h0040,
		EX2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SH_IR = 16'h0800,
		EX1_IR = 16'h1000,
		PA_IR = 16'h2000,
		EX2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} tap_state_t;

	typedef enum logic [2:0] {
		OP_IDLE = 3'h1,
		OP_ERASE = 3'h2,
		OP_WRITE = 3'h4
	} op_state_t;
endpackage

// *** jfp_checker.sv ***
// Port checker for the JTAG flash programming port
`timescale 1ns/1ps
module jfp_checker #(
	parameter logic [17:0] TIMEOUT_SLOW_CYCLES = 18'h3_2000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_en,
	input wire logic target_reset_n,
	input wire logic prog_enabled
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single pulse after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero while idle");
	a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
	a_tdo_moves_low: assert property ($changed(tdo) |-> !tck && !$past(tck))
		else $error("tdo moved while tck high");
	a_tdo_en_low: assert property ($changed(tdo_en) |-> !tck && !$past(tck))
		else $error("tdo_en moved while tck high");
	a_enable_at_rise: assert property ($changed(prog_enabled) |-> tck && $past(tck))
		else $error("prog_enabled moved outside a tck rise");
	a_reset_at_rise: assert property ($fell(target_reset_n) |-> $past(tck) && $past(tck, 2))
		else $error("target reset asserted outside a tck rise");
	c_unmapped: cover property (pslverr);
	c_write: cover property (psel && penable && pready && pwrite);
	c_enabled: cover property ($rose(prog_enabled));
	c_reset: cover property ($fell(target_reset_n));
endmodule
bind jtag_flash_programming_port jfp_checker #(.TIMEOUT_SLOW_CYCLES(TIMEOUT_SLOW_CYCLES)) chk_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.tck, .tdo, .tdo_en, .target_reset_n, .prog_enabled
);

// *** prog_model.sv ***
// External JTAG programmer model driving the TAP pins
`timescale 1ns/1ps
module prog_model (
	input wire logic pclk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One TCK period of 8 pclk, tck parked low; tdo taken just before the rise
	task automatic tick(input logic t, input logic d, output logic q);
		tms <= t;
		tdi <= d;
		repeat (4) @(posedge pclk);
		q = tdo;
		tck <= 1'b1;
		repeat (4) @(posedge pclk);
		tck <= 1'b0;
	endtask
	// From Run-Test/Idle: scan n bits, update, then one idle rise to execute
	task automatic scan(input logic ir, input logic [15:0] din, input int n,
		output logic [15:0] dout);
		logic q;
		dout = 16'h0000;
		tick(1'b1, ~tdi, q);
		if (ir) begin
			tick(1'b1, ~tdi, q);
		end
		tick(1'b0, ~tdi, q);
		tick(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the JTAG flash programming port
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tck, tms, tdi, tdo, tdo_en, target_reset_n, prog_enabled;
	logic [15:0] res;
	logic [7:0] exp_b [6] = '{8'h0a, 8'h1a, 8'h2a, 8'h3a, 8'h4b, 8'h5c};
	int fail_count = 0;
	int compares = 0;

	jtag_flash_programming_port #(.TIMEOUT_SLOW_CYCLES(18'h0_0100)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .tck, .tms, .tdi, .tdo, .tdo_en, .target_reset_n, .prog_enabled
	);
	prog_model prog (.pclk, .tck, .tms, .tdi, .tdo);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic end_sim;
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask

	task automatic ir(input logic [3:0] c);
		logic [15:0] r;
		prog.scan(1'b1, {12'h000, c}, 4, r);
		chk("ir capture", r[3:0], jp_pkg::IR_CAPTURE);
	endtask

	task automatic cmd(input logic [14:0] w);
		prog.scan(1'b0, {1'b0, w}, 15, res);
	endtask

	task automatic poll(input logic [14:0] w);
		int n;
		n = 0;
		do begin
			cmd(w);
			n++;
		end while (res[9] !== 1'b1 && n < 100);
		chk("poll done", res[9], 1'b1);
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic e;
		chk("target after reset", target_reset_n, 1'b1);
		chk("enable after reset", prog_enabled, 1'b0);
		rd(jp_pkg::ADDR_CTRL, r);
		chk("ctrl reset", r, 32'h0000_0001);
		apb(1'b1, jp_pkg::ADDR_STATUS, 32'hffff_ffff, r, e);
		rd(jp_pkg::ADDR_STATUS, r);
		chk("status", r[7:0], 8'h10);
		apb(1'b0, 12'h0ff, 32'h0000_0000, r, e);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", r, 32'h0000_0000);
		apb(1'b1, jp_pkg::ADDR_CTRL, 32'h0000_0003, r, e);
		rd(jp_pkg::ADDR_CTRL, r);
		chk("ctrl", r, 32'h0000_0003);
		prog.tick(1'b0, 1'b1, e);
	endtask

	task automatic t_target_reset;
		logic [31:0] r;
		ir(jp_pkg::IR_TARGET_RESET);
		prog.scan(1'b0, 16'h0001, 1, res);
		chk("reset held", target_reset_n, 1'b0);
		rd(jp_pkg::ADDR_STATUS, r);
		chk("status in reset", r[7:0], 8'hc2);
		prog.scan(1'b0, 16'h0000, 1, res);
		repeat (100) @(posedge pclk);
		chk("reset time-out", target_reset_n, 1'b0);
		repeat (200) @(posedge pclk);
		chk("reset ends", target_reset_n, 1'b1);
	endtask

	task automatic t_enable;
		logic [31:0] r;
		ir(jp_pkg::IR_COMMAND);
		cmd({jp_pkg::PFX_ADDR_LO, 8'h55});
		rd(jp_pkg::ADDR_PC, r);
		chk("pc refused", r[15:0], 16'h0000);
		ir(jp_pkg::IR_PROGRAMMING_ENABLE);
		prog.scan(1'b0, jp_pkg::ENABLE_SIGNATURE ^ 16'h8000, 16, res);
		chk("bad signature", prog_enabled, 1'b0);
		prog.scan(1'b0, jp_pkg::ENABLE_SIGNATURE, 16, res);
		chk("good signature", prog_enabled, 1'b1);
	endtask

	task automatic t_erase;
		ir(jp_pkg::IR_COMMAND);
		cmd({jp_pkg::PFX_ENTER, 8'h80});
		cmd({jp_pkg::PFX_ERASE_START, 8'h80});
		cmd({7'h33, 8'h80});
		chk("erase busy", res[9], 1'b0);
		cmd({7'h33, 8'h80});
		poll({7'h33, 8'h80});
	endtask

	task automatic t_write_read;
		logic [31:0] r;
		cmd({jp_pkg::PFX_ENTER, 8'h10});
		cmd({jp_pkg::PFX_ADDR_HI, 8'h00});
		cmd({jp_pkg::PFX_ADDR_LO, 8'h40});
		ir(jp_pkg::IR_PAGE_LOAD);
		for (int i = 0; i < 4; i++) begin
			prog.scan(1'b0, {8'h00, exp_b[i]}, 8, res);
		end
		rd(jp_pkg::ADDR_PC, r);
		chk("pc after load", r[15:0], 16'h0041);
		ir(jp_pkg::IR_COMMAND);
		cmd({jp_pkg::PFX_ADDR_LO, 8'h42});
		cmd({jp_pkg::PFX_DATA_LO, exp_b[4]});
		cmd({jp_pkg::PFX_DATA_HI, exp_b[5]});
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		cmd({jp_pkg::PFX_LATCH, 8'h00});
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		cmd({jp_pkg::PFX_PAGE_WRITE, 8'h00});
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		chk("write busy", res[9], 1'b0);
		poll({jp_pkg::PFX_READ_HIGH, 8'h00});
		cmd({jp_pkg::PFX_ENTER, 8'h02});
		cmd({jp_pkg::PFX_ADDR_HI, 8'h00});
		cmd({jp_pkg::PFX_ADDR_LO, 8'h40});
		ir(jp_pkg::IR_PAGE_READ);
		for (int i = 0; i < 6; i++) begin
			prog.scan(1'b0, 16'h0000, 8, res);
			chk("page read", res[7:0], exp_b[i]);
		end
		rd(jp_pkg::ADDR_PC, r);
		chk("pc after read", r[15:0], 16'h0043);
		ir(jp_pkg::IR_COMMAND);
		cmd({jp_pkg::PFX_ADDR_LO, 8'h41});
		cmd({jp_pkg::PFX_READ_FETCH, 8'h00});
		cmd({jp_pkg::PFX_READ_LOW, 8'h00});
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		chk("read low", res[7:0], exp_b[2]);
		cmd({jp_pkg::PFX_READ_HIGH, 8'h00});
		chk("read high", res[7:0], exp_b[3]);
	endtask

	task automatic t_leave;
		logic [31:0] r;
		logic e;
		apb(1'b1, jp_pkg::ADDR_CTRL, 32'h0000_0001, r, e);
		ir(jp_pkg::IR_TARGET_RESET);
		prog.scan(1'b0, 16'h0001, 1, res);
		prog.scan(1'b0, 16'h0000, 1, res);
		chk("reset shifted out", res[0], 1'b1);
		chk("short time-out", target_reset_n, 1'b0);
		repeat (60) @(posedge pclk);
		chk("short time-out ends", target_reset_n, 1'b1);
		ir(jp_pkg::IR_PROGRAMMING_ENABLE);
		prog.scan(1'b0, 16'h0000, 16, res);
		chk("enable shifted out", res, jp_pkg::ENABLE_SIGNATURE);
		chk("enable cleared", prog_enabled, 1'b0);
	endtask

	initial begin
		repeat (90000) @(posedge pclk);
		fail_count++;
		end_sim;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs;
		t_target_reset;
		t_enable;
		t_erase;
		t_write_read;
		t_leave;
		end_sim;
	end
endmodule
